// ### hw/pmsc_regs.svh
// Register map, field positions, reset values and timing counts of the power status block
// Behaviour
// - Bit 7 is a sticky warning flag: set while or after supply below warning level.
// - Warning flag sets on falling below the trip point, also right after reset.
// - Writing 1 to bit 6 clears the warning flag only if no warning is present.
// - Bit 5 drives the detect trip point: 0 low threshold, 1 high threshold.
// - Bit 4 drives the warning trip point: 0 low threshold, 1 high threshold.
// - Bit 3 reads 1 when this run started as partial power-down stop recovery.
// - Writing 1 to bit 2 clears the recovery flag in bit 3.
// - Bit 0 picks stop mode on a stop request: 0 full retention, 1 partial.
// - Stop-mode bit takes only the first write after a reset, later writes ignored.
// - Power-on reset clears all bits; other resets keep both trip selects.
// - In partial power-down stop the pin output latches keep their pre-stop values.
// - Full-retention stop keeps all I/O state; I/O resumes directly on wake-up.
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH

`define PMSC_ADDR_CTRL2      4'h0
`define PMSC_ADDR_IRQ_STAT   4'h4
`define PMSC_ADDR_IRQ_EN     4'h8
`define PMSC_ADDR_IRQ_CLR    4'hC

`define PMSC_BIT_WARN_FLAG   7
`define PMSC_BIT_WARN_ACK    6
`define PMSC_BIT_DETECT_SEL  5
`define PMSC_BIT_WARN_SEL    4
`define PMSC_BIT_PPD_FLAG    3
`define PMSC_BIT_PPD_ACK     2
`define PMSC_BIT_STOP_MODE   0

`define PMSC_CTRL2_RESET     8'h00
`define PMSC_IRQ_RESET       3'h0

`define PMSC_IRQ_WARN        0
`define PMSC_IRQ_RECOVERY    1
`define PMSC_IRQ_WAKE        2

`define PMSC_SYNC_STAGES     2

`endif

// ### hw/pmsc_pkg.sv
// Types shared by the power status block
package pmsc_pkg;
    typedef logic [7:0] ctrl_byte_t;
    typedef logic [2:0] irq_bits_t;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_FULL_STOP,
        ST_PARTIAL_STOP
    } stop_state_t;
endpackage : pmsc_pkg

// ### hw/pmsc_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/10ps
module pmsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r   <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r   <= d[i];
                    stable_r <= meta_r;
                end
            end
            assign q[i] = stable_r;
        end
    endgenerate
endmodule : pmsc_sync

// ### hw/power_mgmt_status_control.sv
// Power management status and control register with Wishbone slave and stop sequencing
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module power_mgmt_status_control
    import pmsc_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic        PWR_ON_RESETN,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        WARN_CMP_IN,
    input  wire logic        PPD_WAKE_IN,
    input  wire logic        STOP_REQ,
    input  wire logic        WAKE_REQ,
    output logic             DETECT_TRIP_SEL,
    output logic             WARN_TRIP_SEL,
    output logic             FULL_STOP_ACTIVE,
    output logic             PARTIAL_STOP_ACTIVE,
    output logic             IO_LATCH_HOLD,
    output logic             IRQ
);
    // Any reset clears the non-retained state; power-on reset is part of it
    wire         rst_n_all = RESETN & PWR_ON_RESETN;

    logic [1:0]  sync_q;
    wire         warn_s    = sync_q[0];
    wire         ppd_wake_s = sync_q[1];

    pmsc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk   (SYS_CLK),
        .rst_n (rst_n_all),
        .d     ({PPD_WAKE_IN, WARN_CMP_IN}),
        .q     (sync_q)
    );

    // Bus decode
    logic        ack_r;
    logic [31:0] dat_r;
    wire         bus_req    = CYC_I & STB_I;
    wire         hit_ctrl   = (ADR_I == `PMSC_ADDR_CTRL2);
    wire         hit_stat   = (ADR_I == `PMSC_ADDR_IRQ_STAT);
    wire         hit_en     = (ADR_I == `PMSC_ADDR_IRQ_EN);
    wire         hit_clr    = (ADR_I == `PMSC_ADDR_IRQ_CLR);
    wire         wr_fire    = bus_req & WE_I & ack_r;
    wire         ctrl_wr    = wr_fire & hit_ctrl & SEL_I[0];
    wire         en_wr      = wr_fire & hit_en & SEL_I[0];
    wire         clr_wr     = wr_fire & hit_clr & SEL_I[0];
    wire         warn_ack_wr = ctrl_wr & DAT_I[`PMSC_BIT_WARN_ACK];
    wire         ppd_ack_wr  = ctrl_wr & DAT_I[`PMSC_BIT_PPD_ACK];

    // Register state
    logic        warn_flag_r;
    logic        detect_sel_r;
    logic        warn_sel_r;
    logic        ppd_flag_r;
    logic        stop_mode_r;
    logic        mode_written_r;
    logic        cap_done_r;
    logic [1:0]  cap_cnt_r;
    logic        io_hold_r;
    irq_bits_t   irq_stat_r;
    irq_bits_t   irq_en_r;
    stop_state_t state_r;
    stop_state_t state_nxt;
    localparam ctrl_byte_t ctrl_reset_val = `PMSC_CTRL2_RESET;

    // Recovery strap is caught once the synchroniser has settled after release
    wire         cap_fire   = !cap_done_r && (cap_cnt_r == 2'(`PMSC_SYNC_STAGES));
    wire         rec_set    = cap_fire & ppd_wake_s;

    wire         warn_flag_nxt = warn_s | (warn_flag_r & ~warn_ack_wr);
    wire         ppd_flag_nxt  = rec_set | (ppd_flag_r & ~ppd_ack_wr);

    wire         warn_evt   = warn_s & ~warn_flag_r;
    wire         wake_evt   = (state_r != ST_RUN) & WAKE_REQ;
    wire irq_bits_t irq_evt = {wake_evt, rec_set, warn_evt};
    wire irq_bits_t irq_clr = clr_wr ? DAT_I[2:0] : `PMSC_IRQ_RESET;
    wire irq_bits_t irq_stat_nxt = irq_evt | (irq_stat_r & ~irq_clr);

    wire ctrl_byte_t ctrl_rd = {
        warn_flag_r,
        1'b0,
        detect_sel_r,
        warn_sel_r,
        ppd_flag_r,
        1'b0,
        1'b0,
        stop_mode_r
    };

    wire [31:0]  rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                          hit_stat ? {29'h00000000, irq_stat_r} :
                          hit_en   ? {29'h00000000, irq_en_r} :
                                     32'h00000000;

    // Wishbone answer one cycle after the request
    always_ff @(posedge SYS_CLK or negedge rst_n_all) begin
        if (!rst_n_all) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= bus_req & ~ack_r;
            dat_r <= (bus_req & ~WE_I & ~ack_r) ? rd_mux : 32'h00000000;
        end
    end

    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

    // Trip selects survive every reset but power-on
    always_ff @(posedge SYS_CLK or negedge PWR_ON_RESETN) begin
        if (!PWR_ON_RESETN) begin
            detect_sel_r <= ctrl_reset_val[`PMSC_BIT_DETECT_SEL];
            warn_sel_r   <= ctrl_reset_val[`PMSC_BIT_WARN_SEL];
        end else if (ctrl_wr) begin
            detect_sel_r <= DAT_I[`PMSC_BIT_DETECT_SEL];
            warn_sel_r   <= DAT_I[`PMSC_BIT_WARN_SEL];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_all) begin
        if (!rst_n_all) begin
            warn_flag_r <= 1'b0;
            ppd_flag_r  <= 1'b0;
        end else begin
            warn_flag_r <= warn_flag_nxt;
            ppd_flag_r  <= ppd_flag_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_all) begin
        if (!rst_n_all) begin
            cap_done_r <= 1'b0;
            cap_cnt_r  <= 2'h0;
        end else if (!cap_done_r) begin
            cap_cnt_r  <= cap_cnt_r + 2'h1;
            cap_done_r <= cap_fire;
        end
    end

    // Write-once stop mode select
    always_ff @(posedge SYS_CLK or negedge rst_n_all) begin
        if (!rst_n_all) begin
            stop_mode_r    <= 1'b0;
            mode_written_r <= 1'b0;
        end else if (ctrl_wr && !mode_written_r) begin
            stop_mode_r    <= DAT_I[`PMSC_BIT_STOP_MODE];
            mode_written_r <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_all) begin
        if (!rst_n_all) begin
            irq_stat_r <= `PMSC_IRQ_RESET;
            irq_en_r   <= `PMSC_IRQ_RESET;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (en_wr) begin
                irq_en_r <= DAT_I[2:0];
            end
        end
    end

    assign IRQ = |(irq_stat_r & irq_en_r);

    // Stop sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (STOP_REQ) begin
                    state_nxt = stop_mode_r ? ST_PARTIAL_STOP : ST_FULL_STOP;
                end
            end
            ST_FULL_STOP: begin
                if (WAKE_REQ) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_PARTIAL_STOP: begin
                if (WAKE_REQ) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_all) begin
        if (!rst_n_all) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Pin latch hold spans the recovery reset and ends on the software acknowledge
    wire         hold_set = (state_r == ST_RUN) & STOP_REQ & stop_mode_r;
    always_ff @(posedge SYS_CLK or negedge PWR_ON_RESETN) begin
        if (!PWR_ON_RESETN) begin
            io_hold_r <= 1'b0;
        end else if (hold_set) begin
            io_hold_r <= 1'b1;
        end else if (ppd_ack_wr) begin
            io_hold_r <= 1'b0;
        end
    end

    assign DETECT_TRIP_SEL     = detect_sel_r;
    assign WARN_TRIP_SEL       = warn_sel_r;
    assign FULL_STOP_ACTIVE    = (state_r == ST_FULL_STOP);
    assign PARTIAL_STOP_ACTIVE = (state_r == ST_PARTIAL_STOP);
    assign IO_LATCH_HOLD       = io_hold_r | (state_r == ST_PARTIAL_STOP);

    // Checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n_all);

    sequence s_ctrl_write;
        bus_req && WE_I && hit_ctrl && SEL_I[0] && !ack_r ##1 ack_r;
    endsequence

    sequence s_stop_full;
        state_r == ST_RUN && STOP_REQ && !stop_mode_r && !io_hold_r;
    endsequence

    a_warn_sticky_hold: assert property (warn_flag_r && !warn_ack_wr |=> warn_flag_r)
        else $error("warning flag dropped without acknowledge");

    a_warn_set_input: assert property ($rose(warn_s) |=>
        warn_flag_r && (irq_stat_r[0] || $past(warn_flag_r)))
        else $error("warning flag or event not set by comparator");

    a_warn_ack_clear: assert property (warn_flag_r && warn_ack_wr && !warn_s |=> !warn_flag_r)
        else $error("warning acknowledge did not clear flag");

    a_warn_ack_block: assert property (warn_ack_wr && warn_s |=> warn_flag_r)
        else $error("warning cleared while warning present");

    a_detect_sel_wr: assert property (s_ctrl_write |=> DETECT_TRIP_SEL == $past(DAT_I[5]))
        else $error("detect trip select not updated");

    a_warn_sel_wr: assert property (s_ctrl_write |=> WARN_TRIP_SEL == $past(DAT_I[4]))
        else $error("warning trip select not updated");

    a_ppd_ack_clear: assert property (ppd_ack_wr && !rec_set |=> !ppd_flag_r)
        else $error("recovery flag survived acknowledge");

    a_rec_capture: assert property (cap_fire && ppd_wake_s |=> ppd_flag_r ##0 cap_done_r)
        else $error("recovery flag not captured");

    a_stop_route: assert property (state_r == ST_RUN && STOP_REQ |=>
        (PARTIAL_STOP_ACTIVE == $past(stop_mode_r)) && (FULL_STOP_ACTIVE != $past(stop_mode_r)))
        else $error("stop request entered wrong mode");

    a_mode_once: assert property (mode_written_r && ctrl_wr |=> $stable(stop_mode_r))
        else $error("stop mode changed after first write");

    a_hold_partial: assert property (hold_set |=> IO_LATCH_HOLD [*2])
        else $error("pin latches not held in partial stop");

    a_full_no_hold: assert property (s_stop_full |=> FULL_STOP_ACTIVE && !IO_LATCH_HOLD)
        else $error("full retention stop held pin latches");

    a_read_zero: assert property (ack_r && !WE_I && hit_ctrl |->
        DAT_O[6] == 1'b0 && DAT_O[2:1] == 2'b00)
        else $error("write-only or unused bit read nonzero");

    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");

    a_reset_quiet: assert property (disable iff (1'b0) !rst_n_all [*2] |->
        !ACK_O && DAT_O == 32'h00000000 && !IRQ && !FULL_STOP_ACTIVE && !PARTIAL_STOP_ACTIVE)
        else $error("outputs active during reset");

    a_por_clear: assert property (disable iff (1'b0) !PWR_ON_RESETN [*2] |->
        !DETECT_TRIP_SEL && !WARN_TRIP_SEL && !IO_LATCH_HOLD)
        else $error("power-on reset left a bit set");

    a_sel_keep: assert property (disable iff (!PWR_ON_RESETN) !RESETN |=>
        $stable(DETECT_TRIP_SEL) && $stable(WARN_TRIP_SEL))
        else $error("trip select lost over a non power-on reset");

    a_warn_sync_hi: assert property (rst_n_all && WARN_CMP_IN |-> ##2 warn_s)
        else $error("warning input not passed by synchroniser");

    a_warn_sync_lo: assert property (rst_n_all && !WARN_CMP_IN |-> ##2 !warn_s)
        else $error("warning release not passed by synchroniser");

    a_strap_sync: assert property (rst_n_all && PPD_WAKE_IN |-> ##2 ppd_wake_s)
        else $error("recovery strap not passed by synchroniser");

    a_cap_timing: assert property ($rose(rst_n_all) |-> ##2 cap_fire)
        else $error("recovery strap not sampled on time");

    a_warn_reset_set: assert property ($rose(rst_n_all) && WARN_CMP_IN |-> ##3 warn_flag_r)
        else $error("warning flag not set after reset");

    a_warn_no_spur: assert property (!warn_s && !warn_flag_r |=> !warn_flag_r)
        else $error("warning flag set without warning");

    a_ppd_no_spur: assert property (!cap_fire && !ppd_flag_r |=> !ppd_flag_r)
        else $error("recovery flag set outside capture");

    a_read_fields: assert property (ack_r && !WE_I && hit_ctrl |->
        DAT_O[5:4] == {DETECT_TRIP_SEL, WARN_TRIP_SEL})
        else $error("trip selects read back wrong");

    a_read_upper: assert property (ack_r && !WE_I |-> DAT_O[31:8] == 24'h000000)
        else $error("upper read bits nonzero");

    a_idle_data: assert property (!ACK_O |-> DAT_O == 32'h00000000)
        else $error("read data outside acknowledge");

    a_ack_answer: assert property (rst_n_all && bus_req && !ack_r |=> ACK_O)
        else $error("request not answered next cycle");

    a_mode_first: assert property (ctrl_wr && !mode_written_r |=> stop_mode_r == $past(DAT_I[0]))
        else $error("first stop mode write not taken");

    a_hold_keep: assert property (disable iff (!PWR_ON_RESETN)
        io_hold_r && !ppd_ack_wr |=> IO_LATCH_HOLD)
        else $error("pin latch hold lost before acknowledge");

    a_hold_release: assert property (ppd_ack_wr && !hold_set && state_r == ST_RUN |=>
        !IO_LATCH_HOLD)
        else $error("pin latch hold kept after acknowledge");

    a_partial_stays: assert property (PARTIAL_STOP_ACTIVE && !WAKE_REQ |=> PARTIAL_STOP_ACTIVE)
        else $error("partial stop left without wake");

    a_full_stays: assert property (FULL_STOP_ACTIVE && !WAKE_REQ |=> FULL_STOP_ACTIVE)
        else $error("full stop left without wake");

    a_wake_event: assert property ((FULL_STOP_ACTIVE || PARTIAL_STOP_ACTIVE) && WAKE_REQ |=>
        !FULL_STOP_ACTIVE && !PARTIAL_STOP_ACTIVE && irq_stat_r[2])
        else $error("wake not taken or not flagged");

    a_irq_gate: assert property (irq_en_r == 3'h0 |-> !IRQ)
        else $error("interrupt raised while disabled");

    a_irq_raise: assert property (irq_stat_r[0] && irq_en_r[0] |-> IRQ)
        else $error("enabled warning event not raised");

endmodule : power_mgmt_status_control

// ### sim/supply_stop_model.sv
// Model of the supply comparator and the stop-mode sequencer
`timescale 1ns/10ps
module supply_stop_model (
    input  wire logic       clk,
    input  wire logic [1:0] level,
    input  wire logic       warn_sel,
    input  wire logic       stop_cmd,
    input  wire logic       wake_cmd,
    input  wire logic       part_on,
    input  wire logic       full_on,
    output logic            warn_cmp,
    output logic            ppd_strap,
    output logic            stop_req,
    output logic            wake_req
);
    // Level 2 is below both warning points, level 1 only below the high one
    assign warn_cmp = (level == 2'h2) || (level == 2'h1 && warn_sel);

    initial begin
        ppd_strap = 1'b0;
        stop_req = 1'b0;
        wake_req = 1'b0;
    end

    // Strap tells the next run whether the last stop was the partial one
    always @(posedge clk) begin
        stop_req <= stop_cmd;
        wake_req <= wake_cmd;
        if (part_on) begin
            ppd_strap <= 1'b1;
        end else if (full_on) begin
            ppd_strap <= 1'b0;
        end
    end
endmodule : supply_stop_model

// ### sim/power_mgmt_status_control_test.sv
// Self-checking bench for the power management status and control block
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module power_mgmt_status_control_test;
    logic        clk, rst_n, por_n, cyc, stb, we, ack;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat;
    logic [1:0]  supply_lvl;
    logic        stop_cmd, wake_cmd, warn_cmp, ppd_strap, stop_req, wake_req;
    logic        det_sel, warn_sel, full_on, part_on, io_hold, irq;
    int          bad_count;
    int          num_checks;

    power_mgmt_status_control DUT (
        .SYS_CLK(clk), .RESETN(rst_n), .PWR_ON_RESETN(por_n),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
        .WARN_CMP_IN(warn_cmp), .PPD_WAKE_IN(ppd_strap),
        .STOP_REQ(stop_req), .WAKE_REQ(wake_req),
        .DETECT_TRIP_SEL(det_sel), .WARN_TRIP_SEL(warn_sel),
        .FULL_STOP_ACTIVE(full_on), .PARTIAL_STOP_ACTIVE(part_on),
        .IO_LATCH_HOLD(io_hold), .IRQ(irq)
    );

    supply_stop_model partner (
        .clk(clk), .level(supply_lvl), .warn_sel(warn_sel),
        .stop_cmd(stop_cmd), .wake_cmd(wake_cmd), .part_on(part_on),
        .full_on(full_on), .warn_cmp(warn_cmp), .ppd_strap(ppd_strap),
        .stop_req(stop_req), .wake_req(wake_req)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, 4'hF, q);
        check(q, e);
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic hit_reset(input logic por);
        rst_n <= 1'b0;
        por_n <= ~por;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : hit_reset

    task automatic cmd(input logic wake);
        if (wake) begin
            wake_cmd <= 1'b1;
        end else begin
            stop_cmd <= 1'b1;
        end
        @(posedge clk);
        wake_cmd <= 1'b0;
        stop_cmd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : cmd

    task automatic t_selects;
        logic [7:0] q;
        rd(`PMSC_ADDR_CTRL2, 8'h00);
        rd(4'h2, 8'h00);
        wr(`PMSC_ADDR_CTRL2, 8'h77);
        rd(`PMSC_ADDR_CTRL2, 8'h31);
        check({6'h00, det_sel, warn_sel}, 8'h03);
        wr(`PMSC_ADDR_CTRL2, 8'h00);
        rd(`PMSC_ADDR_CTRL2, 8'h01);
        // Write with the low byte lane off must be ignored
        wb(1'b1, `PMSC_ADDR_CTRL2, 8'h30, 4'h0, q);
        rd(`PMSC_ADDR_CTRL2, 8'h01);
        wr(`PMSC_ADDR_CTRL2, 8'h30);
        hit_reset(1'b0);
        rd(`PMSC_ADDR_CTRL2, 8'h30);
        wr(`PMSC_ADDR_CTRL2, 8'h21);
        rd(`PMSC_ADDR_CTRL2, 8'h21);
        hit_reset(1'b1);
        rd(`PMSC_ADDR_CTRL2, 8'h00);
    endtask : t_selects

    task automatic t_warning;
        supply_lvl <= 2'h1;
        repeat (5) @(posedge clk);
        rd(`PMSC_ADDR_CTRL2, 8'h00);
        wr(`PMSC_ADDR_CTRL2, 8'h10);
        repeat (5) @(posedge clk);
        rd(`PMSC_ADDR_CTRL2, 8'h90);
        check({7'h00, irq}, 8'h00);
        rd(`PMSC_ADDR_IRQ_STAT, 8'h01);
        wr(`PMSC_ADDR_IRQ_EN, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(`PMSC_ADDR_CTRL2, 8'h50);
        rd(`PMSC_ADDR_CTRL2, 8'h90);
        supply_lvl <= 2'h0;
        repeat (5) @(posedge clk);
        rd(`PMSC_ADDR_CTRL2, 8'h90);
        wr(`PMSC_ADDR_IRQ_CLR, 8'h01);
        check({7'h00, irq}, 8'h00);
        wr(`PMSC_ADDR_CTRL2, 8'h50);
        rd(`PMSC_ADDR_CTRL2, 8'h10);
        supply_lvl <= 2'h2;
        hit_reset(1'b0);
        rd(`PMSC_ADDR_CTRL2, 8'h90);
        supply_lvl <= 2'h0;
    endtask : t_warning

    task automatic t_stop;
        hit_reset(1'b1);
        wr(`PMSC_ADDR_CTRL2, 8'h01);
        cmd(1'b0);
        check({5'h00, full_on, part_on, io_hold}, 8'h03);
        cmd(1'b1);
        check({5'h00, full_on, part_on, io_hold}, 8'h01);
        rd(`PMSC_ADDR_IRQ_STAT, 8'h04);
        hit_reset(1'b0);
        rd(`PMSC_ADDR_CTRL2, 8'h08);
        rd(`PMSC_ADDR_IRQ_STAT, 8'h02);
        check({7'h00, io_hold}, 8'h01);
        wr(`PMSC_ADDR_CTRL2, 8'h04);
        rd(`PMSC_ADDR_CTRL2, 8'h00);
        check({7'h00, io_hold}, 8'h00);
        cmd(1'b0);
        check({5'h00, full_on, part_on, io_hold}, 8'h04);
        cmd(1'b1);
        check({5'h00, full_on, part_on, io_hold}, 8'h00);
        hit_reset(1'b0);
        rd(`PMSC_ADDR_CTRL2, 8'h00);
    endtask : t_stop

    initial begin
        bad_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        por_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h00000000;
        supply_lvl = 2'h0;
        stop_cmd = 1'b0;
        wake_cmd = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_selects();
        t_warning();
        t_stop();
        final_report();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule : power_mgmt_status_control_test
